// [rtl/flash_bus_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef FLASH_BUS_MAP_SVH
`define FLASH_BUS_MAP_SVH
`define FB_OFS_CONFIG     8'h00
`define FB_OFS_STATUS     8'h04
`define FB_OFS_CMD_ADDR   8'h08
`define FB_OFS_CMD_DATA   8'h0C
`define FB_CFG_RESET      16'h8000
`define FB_CFG_MASK       16'hFBCF
`define FB_READ_SEL       15
`define FB_XLAT_HI        14
`define FB_XLAT_LO        11
`define FB_WORD_LAT       9
`define FB_VALID_TIMING   8
`define FB_EDGE_SEL       6
`define FB_LATCH_RD       3
`define FB_BL_HI          2
`define FB_BL_LO          0
`define FB_BL_4           3'b001
`define FB_BL_8           3'b010
`define FB_BL_CONT        3'b111
`define FB_CLK_NS         40
`define FB_IDLE_NS        200
`define FB_IDLE_CYC       ((`FB_IDLE_NS + `FB_CLK_NS - 1) / `FB_CLK_NS)
`endif

// [rtl/flash_bus_pkg.sv]
// Types shared by the flash bus interface
package flash_bus_pkg;
    typedef enum logic [2:0] {
        MODE_POWERDOWN = 3'b000,
        MODE_STANDBY   = 3'b001,
        MODE_WRITE     = 3'b010,
        MODE_ASYNC     = 3'b011,
        MODE_BURST     = 3'b100,
        MODE_IDLE      = 3'b101
    } bus_mode_e;
endpackage

// [rtl/flash_bus_interface.sv]
// Flash bus interface: async writes, async reads, synchronous bursts
// Function
// (RQ1) Write address captured at latch strobe rising
// (RQ2) Write data captured on first enable rise
// (RQ3) Clock input ignored during writes
// (RQ4) Host keeps output enable high writing
// (RQ5) Output enable high tri-states data
// (RQ6) Chip enable high gives standby, tri-state
// (RQ7) Program or erase survives standby
// (RQ8) Idle async read enters low power
// (RQ9) Power-down input low tri-states everything
// (RQ10) Latch-mode bit picks random or latched reads
// (RQ11) Bursts only with 16-bit organisation
// (RQ12) Burst address latched first edge or strobe
// (RQ13) First data after initial latency
// (RQ14) Advance input and word latency step counter
// (RQ15) Continuous burst wraps whole array
// (RQ16) Output enable and advance high suspend
// (RQ17) Unaligned continuous start requests wait
// (RQ18) Host pipelines only with one-cycle words
// (RQ19) New latch pulse mid-burst restarts latency
// (RQ20) Pipeline switch inserts invalid word period
// (RQ21) Host pipelines only four-word bursts
// (RQ22) Host avoids suspending pipelined bursts
// (RQ23) Read-select bit set after reset
// (RQ24) Edge bit picks active clock edge
// (RQ25) Timing bit moves data-valid one clock early
// (RQ26) Host latches pipelined address at best cycle
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "flash_bus_map.svh"
module flash_bus_interface #(
    parameter int AW = 21,
    parameter int DW = 32
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Flash bus pins
    input  wire logic [AW-1:0] address,
    input  wire logic [DW-1:0] dqIn,
    output logic [DW-1:0]      dqOut,
    output logic               dqOe,
    input  wire logic          chipEnableN,
    input  wire logic          outputEnableN,
    input  wire logic          writeEnableN,
    input  wire logic          latchEnableN,
    input  wire logic          advanceN,
    input  wire logic          flashClock,
    input  wire logic          reset_powerdown_n,
    input  wire logic          wordWide16,
    output logic               validReady,
    output logic               validReadyOe,
    // Array and command side
    output logic [AW-1:0]      arrayAddr,
    input  wire logic [DW-1:0] arrayData,
    output logic               cmdStrobe,
    output logic [AW-1:0]      cmdAddr,
    output logic [DW-1:0]      cmdData,
    input  wire logic          programBusy,
    output logic               standbyLowCurrent,
    output logic               autoLowPower
);
    localparam int NC = 8;
    localparam int IDLE = `FB_IDLE_CYC;

    logic [NC-1:0] ctlA, ctlB, ctlC;
    logic [AW-1:0] addrA, addrB, addrC;
    logic [DW-1:0] dqA, dqB, dqC;
    logic [15:0]   cfgReg;
    logic [AW-1:0] latchAddr, burstAddr, pendAddr;
    logic [3:0]    latCnt, pendCnt;
    logic          gapCnt, pendOn, oddWait, burstOn, strobeUsed;
    logic [7:0]    idleCnt;
    flash_bus_pkg::bus_mode_e mode;

    // Synchronised pin levels
    wire rpS    = ctlB[7];
    wire ceS    = ctlB[6];
    wire oeS    = ctlB[5];
    wire weS    = ctlB[4];
    wire leS    = ctlB[3];
    wire advS   = ctlB[2];
    wire kS     = ctlB[1];
    wire w16S   = ctlB[0];

    // Configuration fields
    wire       readSel  = cfgReg[`FB_READ_SEL];
    wire [3:0] xLat     = cfgReg[`FB_XLAT_HI:`FB_XLAT_LO];
    wire       wordLat  = cfgReg[`FB_WORD_LAT];
    wire       vTiming  = cfgReg[`FB_VALID_TIMING];
    wire       edgeSel  = cfgReg[`FB_EDGE_SEL];
    wire       latchRd  = cfgReg[`FB_LATCH_RD];
    wire [2:0] burstLen = cfgReg[`FB_BL_HI:`FB_BL_LO];

    wire kRise   = kS & ~ctlC[1];
    wire kFall   = ~kS & ctlC[1];
    wire leRise  = leS & ~ctlC[3];
    wire wrNow   = ~ceS & ~weS;
    wire wrPrev  = ~ctlC[6] & ~ctlC[4];
    wire wrEnd   = wrPrev & ~wrNow;
    wire syncRd  = ~readSel & w16S;                          // (RQ11)
    wire actEdge = (edgeSel ? kRise : kFall) & ~wrNow;       // (RQ24) (RQ3)
    wire burstGo = actEdge & ~ceS & weS & ~leS & ~strobeUsed;
    wire contMode = burstLen == `FB_BL_CONT;
    wire dataOk  = latCnt == 4'h0;

    function automatic logic [AW-1:0] nextAddr(input logic [AW-1:0] a, input logic [2:0] bl);
        logic [AW-1:0] n;
        n = a + AW'(1);
        case (bl)
            `FB_BL_4:    nextAddr = {a[AW-1:2], n[1:0]};
            `FB_BL_8:    nextAddr = {a[AW-1:3], n[2:0]};
            `FB_BL_CONT: nextAddr = n;                       // (RQ15)
            default:     nextAddr = {a[AW-1:2], n[1:0]};
        endcase
    endfunction

    function automatic logic apbHit(input logic [7:0] a, input logic [7:0] ofs);
        apbHit = a == ofs;
    endfunction

    // Two-stage synchroniser, third stage for edges
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctlA  <= 8'h7C;
            ctlB  <= 8'h7C;
            ctlC  <= 8'h7C;
            addrA <= '0;
            addrB <= '0;
            addrC <= '0;
            dqA   <= '0;
            dqB   <= '0;
            dqC   <= '0;
        end
        else
        begin
            ctlA  <= {reset_powerdown_n, chipEnableN, outputEnableN, writeEnableN,
                      latchEnableN, advanceN, flashClock, wordWide16};
            ctlB  <= ctlA;
            ctlC  <= ctlB;
            addrA <= address;
            addrB <= addrA;
            addrC <= addrB;
            dqA   <= dqIn;
            dqB   <= dqA;
            dqC   <= dqB;
        end
    end

    // Bus mode decode
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mode <= flash_bus_pkg::MODE_POWERDOWN;
        else if (!rpS)
            mode <= flash_bus_pkg::MODE_POWERDOWN;           // (RQ9)
        else if (ceS)
            mode <= flash_bus_pkg::MODE_STANDBY;             // (RQ6)
        else if (!weS)
            mode <= flash_bus_pkg::MODE_WRITE;
        else if (burstOn)
            mode <= flash_bus_pkg::MODE_BURST;
        else if (readSel)
            mode <= flash_bus_pkg::MODE_ASYNC;
        else
            mode <= flash_bus_pkg::MODE_IDLE;
    end

    // Configuration register, reloaded with its reset value by power-down
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cfgReg <= `FB_CFG_RESET;                         // (RQ23)
        else if (!rpS)
            cfgReg <= `FB_CFG_RESET;
        else if (psel && penable && pwrite && apbHit(paddr, `FB_OFS_CONFIG))
            cfgReg <= pwdata[15:0] & `FB_CFG_MASK;
    end

    // Address latch, transparent while strobe low
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            latchAddr <= '0;
        else if (!leS)
            latchAddr <= addrB;                              // (RQ1) (RQ10)
    end

    // Command capture on first enable rise
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cmdStrobe <= 1'b0;
            cmdAddr   <= '0;
            cmdData   <= '0;
        end
        else
        begin
            cmdStrobe <= wrEnd & rpS;
            if (wrEnd && rpS)
            begin
                cmdAddr <= latchAddr;                        // (RQ1)
                cmdData <= dqC;                              // (RQ2)
            end
        end
    end

    // Burst engine
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            burstOn    <= 1'b0;
            burstAddr  <= '0;
            latCnt     <= 4'h0;
            gapCnt     <= 1'b0;
            oddWait    <= 1'b0;
            strobeUsed <= 1'b0;
            pendOn     <= 1'b0;
            pendAddr   <= '0;
            pendCnt    <= 4'h0;
        end
        else if (!rpS || ceS || !syncRd)
        begin
            burstOn    <= 1'b0;
            pendOn     <= 1'b0;
            strobeUsed <= 1'b0;
            oddWait    <= 1'b0;
            latCnt     <= 4'h0;
        end
        else
        begin
            if (leS)
                strobeUsed <= 1'b0;
            if (burstOn && (burstGo || leRise && !strobeUsed))
            begin
                pendOn     <= 1'b1;                          // (RQ19)
                pendAddr   <= burstGo ? addrB : latchAddr;
                pendCnt    <= xLat;
                strobeUsed <= burstGo;
            end
            else if (!burstOn && (burstGo || leRise && !strobeUsed && weS))
            begin
                burstOn    <= 1'b1;                          // (RQ12)
                burstAddr  <= burstGo ? addrB : latchAddr;
                latCnt     <= xLat;                          // (RQ13)
                gapCnt     <= 1'b0;
                oddWait    <= contMode & (burstGo ? addrB[0] : latchAddr[0]); // (RQ17)
                strobeUsed <= burstGo;
            end
            else if (actEdge && burstOn)
            begin
                if (pendOn && pendCnt <= 4'h1)
                begin
                    pendOn    <= 1'b0;
                    burstAddr <= pendAddr;
                    latCnt    <= {3'b000, 1'b1} + {3'b000, wordLat}; // (RQ20)
                    gapCnt    <= 1'b0;
                end
                else
                begin
                    if (pendOn)
                        pendCnt <= pendCnt - 4'h1;
                    if (!dataOk)
                        latCnt <= latCnt - 4'h1;
                    else if (!advS)                          // (RQ14) (RQ16)
                    begin
                        if (gapCnt != wordLat)
                            gapCnt <= ~gapCnt;
                        else if (oddWait)
                            oddWait <= 1'b0;                 // (RQ17)
                        else
                        begin
                            burstAddr <= nextAddr(burstAddr, burstLen);
                            gapCnt    <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // Data-valid flag, normal or one clock early
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            validReady <= 1'b1;
        else if (!burstOn)
            validReady <= 1'b1;
        else if (actEdge)
        begin
            if (vTiming)                                     // (RQ25)
                validReady <= !(latCnt > 4'h2 || oddWait && latCnt <= 4'h1
                                || pendOn && pendCnt <= 4'h2);
            else
                validReady <= !(latCnt > 4'h1 || oddWait && dataOk && !advS
                                || pendOn && pendCnt <= 4'h1);
        end
    end

    // Idle detection for automatic low power
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            idleCnt <= 8'h00;
        else if (mode != flash_bus_pkg::MODE_ASYNC || ctlB != ctlC || addrB != addrC)
            idleCnt <= 8'h00;                                // (RQ8)
        else if (idleCnt < 8'(IDLE))
            idleCnt <= idleCnt + 8'h01;
    end

    // Array address and read data
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            arrayAddr <= '0;
            dqOut     <= '0;
        end
        else
        begin
            if (burstOn)
                arrayAddr <= burstAddr;
            else if (latchRd)
                arrayAddr <= latchAddr;                      // (RQ10)
            else
                arrayAddr <= addrB;
            if (w16S)
                dqOut <= {{(DW-16){1'b0}}, arrayData[15:0]};
            else
                dqOut <= arrayData;
        end
    end

    // Output drivers and power flags
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dqOe              <= 1'b0;
            validReadyOe      <= 1'b0;
            standbyLowCurrent <= 1'b0;
            autoLowPower      <= 1'b0;
        end
        else
        begin
            dqOe <= rpS & ~ceS & ~oeS & weS                  // (RQ5) (RQ6) (RQ9)
                    & (readSel | burstOn & dataOk);          // (RQ13) (RQ16)
            validReadyOe      <= rpS & ~ceS;                 // (RQ9)
            standbyLowCurrent <= ceS & rpS & ~programBusy;   // (RQ7)
            autoLowPower      <= idleCnt >= 8'(IDLE);        // (RQ8)
        end
    end

    // APB read data, sampled in the setup cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr <= 1'b0;
            if (apbHit(paddr, `FB_OFS_CONFIG))
                prdata <= {16'h0000, cfgReg};
            else if (apbHit(paddr, `FB_OFS_STATUS))
                prdata <= {22'h00_0000, programBusy, autoLowPower, validReady,
                           burstOn, pendOn, w16S, 1'b0, mode};
            else if (apbHit(paddr, `FB_OFS_CMD_ADDR))
                prdata <= 32'(cmdAddr);
            else if (apbHit(paddr, `FB_OFS_CMD_DATA))
                prdata <= 32'(cmdData);
            else
            begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b1;
            end
        end
    end

    assign pready = 1'b1;
endmodule // flash_bus_interface

// [tb/flash_bus_interface_assertions.sv]
// Port-level checks of the flash bus interface
`timescale 1ns/1ps
module flash_bus_interface_assertions #(
    parameter int AW = 21
) (
    // Clock and reset
    input wire logic          clk,
    input wire logic          reset,
    // Watched ports
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [7:0]    paddr,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          dqOe,
    input wire logic          validReadyOe,
    input wire logic          chipEnableN,
    input wire logic          outputEnableN,
    input wire logic          reset_powerdown_n,
    input wire logic          cmdStrobe,
    input wire logic          programBusy,
    input wire logic          standbyLowCurrent,
    input wire logic          autoLowPower,
    input wire logic [AW-1:0] address
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("apb access not ready");
    property p_slverr;
        psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h0C);
    endproperty
    a_slverr: assert property (p_slverr) else $error("apb error flag wrong");
    property p_pulse;
        cmdStrobe |=> !cmdStrobe;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
    property p_outdis;
        outputEnableN [*4] |-> !dqOe;
    endproperty
    a_outdis: assert property (p_outdis) else $error("data driven with output enable high");
    property p_standby;
        chipEnableN [*4] |-> !dqOe;
    endproperty
    a_standby: assert property (p_standby) else $error("data driven in standby");
    property p_pdown;
        !reset_powerdown_n [*4] |-> !dqOe && !validReadyOe && !cmdStrobe;
    endproperty
    a_pdown: assert property (p_pdown) else $error("activity in power-down");
    property p_busy;
        programBusy [*4] |-> !standbyLowCurrent;
    endproperty
    a_busy: assert property (p_busy) else $error("low current while busy");
    property p_wake;
        !$stable(address) |-> ##[1:5] !autoLowPower;
    endproperty
    a_wake: assert property (p_wake) else $error("low power kept on bus change");
endmodule // flash_bus_interface_assertions

bind flash_bus_interface flash_bus_interface_assertions #(.AW(AW)) u_chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .dqOe(dqOe), .validReadyOe(validReadyOe), .chipEnableN(chipEnableN),
    .outputEnableN(outputEnableN), .reset_powerdown_n(reset_powerdown_n), .cmdStrobe(cmdStrobe),
    .programBusy(programBusy), .standbyLowCurrent(standbyLowCurrent), .autoLowPower(autoLowPower),
    .address(address)
);

// [tb/flash_host.sv]
// Host model driving the flash bus pins
`timescale 1ns/1ps
module flash_host #(
    parameter int AW = 21,
    parameter int DW = 32
) (
    // Clock
    input  wire logic     clk,
    // Flash bus, ctl is chip, output, write, latch, advance enables
    output logic [AW-1:0] address,
    output logic [DW-1:0] dqIn,
    output logic [4:0]    ctl,
    output logic          flashClock
);
    initial
    begin
        address = '0;
        dqIn = '0;
        ctl = 5'b11111;
        flashClock = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pins(input logic [4:0] v);
        ctl <= v;
    endtask
    // Clock stands low between frames
    task automatic kedge();
        flashClock <= 1'b1;
        tick(4);
        flashClock <= 1'b0;
        tick(4);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        address <= a;
        ctl <= 5'b11101;
        tick(4);
        ctl <= 5'b11111;
        address <= ~a;
        tick(4);
        ctl <= 5'b01011;
        dqIn <= d;
        tick(4);
        ctl <= 5'b01111;
        tick(4);
        ctl <= 5'b11111;
        dqIn <= ~d;
    endtask
    // Latched read moves the address away after the latch
    task automatic rd(input logic [AW-1:0] a, input logic lat);
        address <= a;
        ctl <= {3'b011, !lat, 1'b1};
        tick(4);
        if (lat)
            address <= ~a;
        ctl <= 5'b00111;
    endtask
    task automatic bst(input logic [AW-1:0] a);
        address <= a;
        ctl <= 5'b00100;
        tick(1);
        kedge();
        ctl <= 5'b00110;
        address <= ~a;
    endtask
endmodule // flash_host

// [tb/flash_bus_interface_tb.sv]
// Self-checking bench for the flash bus interface
`timescale 1ns/1ps
`include "flash_bus_map.svh"
module flash_bus_interface_tb;
    logic        clk, reset, psel, penable, pwrite, flashClock;
    logic        reset_powerdown_n, wordWide16, programBusy, lastErr;
    logic        pready, pslverr, dqOe, validReady, validReadyOe;
    logic        cmdStrobe, standbyLowCurrent, autoLowPower;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, dqIn, dqOut, arrayData, cmdData, r;
    logic [20:0] address, arrayAddr, cmdAddr;
    logic [4:0]  ctl;
    int          mismatches, samples_checked, cycles, n;

    function automatic logic [31:0] arr(input logic [20:0] a);
        return {a[10:0], a};
    endfunction
    function automatic logic [31:0] w16(input logic [20:0] a);
        return {16'h0000, a[15:0]};
    endfunction
    assign arrayData = arr(arrayAddr);

    flash_bus_interface u_dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .address(address),
        .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .chipEnableN(ctl[4]), .outputEnableN(ctl[3]),
        .writeEnableN(ctl[2]), .latchEnableN(ctl[1]), .advanceN(ctl[0]), .flashClock(flashClock),
        .reset_powerdown_n(reset_powerdown_n), .wordWide16(wordWide16), .validReady(validReady),
        .validReadyOe(validReadyOe), .arrayAddr(arrayAddr), .arrayData(arrayData),
        .cmdStrobe(cmdStrobe), .cmdAddr(cmdAddr), .cmdData(cmdData), .programBusy(programBusy),
        .standbyLowCurrent(standbyLowCurrent), .autoLowPower(autoLowPower)
    );
    flash_host u_host (.clk(clk), .address(address), .dqIn(dqIn), .ctl(ctl), .flashClock(flashClock));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apbIdle;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= 8'h00;
        pwdata  <= 32'h0000_0000;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial
    begin
        {programBusy, wordWide16} = '0;
        apbIdle();
        reset = 1'b1;
        reset_powerdown_n = 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        apb(0, `FB_OFS_CONFIG, 32'h0);
        chk("config reset", 32'h0000_8000, r);
        apb(1, `FB_OFS_CONFIG, 32'hFFFF_FFFF);
        apb(0, `FB_OFS_CONFIG, 32'h0);
        chk("config mask", {16'h0000, `FB_CFG_MASK}, r);
        apb(0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, lastErr});
        chk("unmapped data", 32'h0, r);
        u_host.rd(21'h0_0ABC, 1'b1);
        repeat (8) @(posedge clk);
        chk("latched read", arr(21'h0_0ABC), dqOut);
        repeat (8) @(posedge clk);
        chk("low power", 32'h3, {30'h0, autoLowPower, dqOe});
        reset_powerdown_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("powerdown drive", 32'h0, {30'h0, dqOe, validReadyOe});
        reset_powerdown_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb(0, `FB_OFS_CONFIG, 32'h0);
        chk("config restored", 32'h0000_8000, r);
        u_host.pins(5'b11111);
        @(posedge clk);
        u_host.rd(21'h1_5555, 1'b0);
        repeat (8) @(posedge clk);
        chk("random read", arr(21'h1_5555), dqOut);
        u_host.pins(5'b01111);
        repeat (5) @(posedge clk);
        chk("output disable", 32'h0, {31'h0, dqOe});
        u_host.pins(5'b10011);
        repeat (5) @(posedge clk);
        chk("standby", 32'h1, {30'h0, dqOe, standbyLowCurrent});
        programBusy <= 1'b1;
        repeat (5) @(posedge clk);
        chk("busy current", 32'h0, {31'h0, standbyLowCurrent});
        programBusy <= 1'b0;
        u_host.pins(5'b11111);
        @(posedge clk);
        n = 0;
        fork
            u_host.wr(21'h0_1234, 32'hCAFE_0001);
            begin
                u_host.tick(9);
                u_host.kedge();
            end
            while (cmdStrobe !== 1'b1 && n < 40)
            begin
                @(posedge clk);
                n++;
            end
        join
        chk("strobe seen", 32'h1, {31'h0, n < 40});
        chk("write address", {11'h0, 21'h0_1234}, {11'h0, cmdAddr});
        chk("write data", 32'hCAFE_0001, cmdData);
        apb(1, `FB_OFS_CONFIG, 32'h0000_1841);
        wordWide16 <= 1'b1;
        u_host.bst(21'h0_0100);
        n = 0;
        do
        begin
            u_host.kedge();
            n++;
        end
        while (!(validReady === 1'b1 && dqOe === 1'b1) && n < 30);
        for (int i = 0; i < 5; i++)
        begin
            chk("burst word", w16(21'h0_0100 + 21'(i % 4)), dqOut);
            if (i < 4)
                u_host.kedge();
        end
        u_host.pins(5'b01111);
        u_host.tick(2);
        u_host.kedge();
        u_host.kedge();
        chk("suspended drive", 32'h0, {31'h0, dqOe});
        u_host.pins(5'b00111);
        u_host.tick(2);
        u_host.kedge();
        chk("resumed word", w16(21'h0_0100), dqOut);
        u_host.bst(21'h0_0200);
        repeat (3) u_host.kedge();
        chk("pipeline gap", 32'h0, {30'h0, validReady, dqOe});
        u_host.kedge();
        chk("pipeline flags", 32'h3, {30'h0, validReady, dqOe});
        chk("pipeline word", w16(21'h0_0200), dqOut);
        summarize();
    end
endmodule // flash_bus_interface_tb
